/* File: core/reset_seq_pkg.sv */
// Constants, field layout and carrier types of the reset sequencer.
// Assumes a 50 MHz CPU clock and a 32-bit APB register port.
package reset_seq_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 50;
   // Least width of the driven reset pulse, in ns
   localparam int MIN_PULSE_NS = 1000;
   localparam int DELAY_SHORT_CYC = 256;
   localparam int DELAY_LONG_CYC = 4096;
   localparam int FETCH_CYC = 2;
   localparam int CNT_W = 13;

   // -----------------------------------------------------------------
   // Memory map and register layout
   // -----------------------------------------------------------------
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
   localparam logic [11:0] SUPPLY_CTRL_STATUS_ADDR = 12'h000;
   localparam logic [7:0] SUPPLY_CTRL_STATUS_RESET = 8'h00;
   localparam int IRQ_ENABLE_BIT = 6;
   localparam int EARLY_FLAG_BIT = 5;
   localparam int UNDERVOLT_BIT = 4;
   localparam int PLL_LOCK_BIT = 3;
   localparam int WDG_CAUSE_BIT = 0;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_ACTIVE, SEQ_DELAY, SEQ_FETCH, SEQ_RUN
   } seq_state_t;

   typedef enum logic [2:0] {
      SRC_POWER, SRC_PIN, SRC_WATCHDOG, SRC_UNDERVOLT, SRC_ILLEGAL
   } reset_src_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic lvd_enable;
      logic [1:0] lvd_level;
      logic long_delay;
   } option_t;

endpackage

/* File: core/reset_sequencer.sv */
// Reset sequencer with supply monitor status register.
// Assumes comparator, option and mode inputs synchronous to core_clk,
// except the reset pin, which is caught asynchronously.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Reset requests come from pin, undervoltage, watchdog and illegal op.
// - Reset pin is driven low through the whole stabilisation delay.
// - After reset the vector is fetched from the top two bytes.
// - Sequence: active phase, 256 or 4096 cycle delay by option, fetch.
// - Vector fetch lasts exactly two clock cycles.
// - Low reset pin is caught asynchronously, even with clocks stopped.
// - Recognised pin reset is driven low at least the minimum width.
// - Watchdog underflow drives pin low minimum width and runs sequence.
// - Pin held low while supply is below the undervoltage threshold.
// - Undervoltage detector enable and level come from option setting.
// - Early-warning detector works only with undervoltage detector on.
// - Falling below early-warning threshold sets flag and raises request.
// - Rising above threshold clears flag by hardware with no interrupt.
// - Wait: logic runs and wakes; Halt: live flags and writes frozen, cause flags still set, no wake.
// - Bit 6 enables; flag rise makes pending request, cleared on entry.
// - Bit 5 early-warning flag is read-only, hardware maintained.
// - Bit 4 set on undervoltage reset, cleared by software zero.
// - Bit 3 shows PLL lock, hardware only.
// - Bit 0 set on watchdog reset; cleared by zero, pin or undervoltage reset.
// - Cause flags: pin x/0, watchdog x/1, undervoltage 1/0.
// - Pin or watchdog reset leaves the undervoltage flag untouched.
module reset_sequencer #(
   parameter int MIN_PULSE_NS = reset_seq_pkg::MIN_PULSE_NS,
   parameter int DELAY_SHORT_CYC = reset_seq_pkg::DELAY_SHORT_CYC,
   parameter int DELAY_LONG_CYC = reset_seq_pkg::DELAY_LONG_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire reset_seq_pkg::apb_req_t apb_req,
   output reset_seq_pkg::apb_rsp_t apb_rsp,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire reset_seq_pkg::option_t options,
   input wire logic supply_below_lvd,
   input wire logic supply_below_early,
   input wire logic watchdog_underflow,
   input wire logic illegal_opcode,
   input wire logic pll_locked,
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic irq_entered,
   output logic lvd_enable,
   output logic [1:0] lvd_threshold_sel,
   output logic early_warning_enable,
   output logic core_reset_n,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic early_warning_irq,
   output logic wait_wakeup
);

   // -----------------------------------------------------------------
   // Derived counts
   // -----------------------------------------------------------------
   localparam int CNT_W = reset_seq_pkg::CNT_W;
   localparam int PULSE_RAW =
      (MIN_PULSE_NS * reset_seq_pkg::CLK_FREQ_MHZ + 999) / 1000;
   localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
   localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(DELAY_SHORT_CYC - 1);
   localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(DELAY_LONG_CYC - 1);
   localparam logic [CNT_W-1:0] FETCH_LAST =
      CNT_W'(reset_seq_pkg::FETCH_CYC - 1);

   function automatic logic reg_hit(input reset_seq_pkg::apb_req_t r);
      reg_hit = r.paddr == reset_seq_pkg::SUPPLY_CTRL_STATUS_ADDR;
   endfunction

   reset_seq_pkg::seq_state_t state;
   reset_seq_pkg::reset_src_t source;
   logic [CNT_W-1:0] cnt;
   logic pin_clr_n;
   logic pin_meta_n;
   logic pin_sync_n;
   logic lvd_low;
   logic early_low;
   logic event_pulse;
   logic active_done;
   logic delay_done;
   logic fetch_done;
   logic irq_enable;
   logic early_flag;
   logic undervolt_flag;
   logic pll_lock_flag;
   logic wdg_flag;
   logic irq_pending;
   logic wr_en;
   logic rd_setup;
   logic [7:0] status;
   logic [31:0] rd_data;
   logic pin_drive_hold;

   // -----------------------------------------------------------------
   // Option driven detector controls
   // -----------------------------------------------------------------
   assign lvd_enable = options.lvd_enable;
   assign lvd_threshold_sel = options.lvd_level;
   assign early_warning_enable = options.lvd_enable;
   assign lvd_low = options.lvd_enable && supply_below_lvd;
   assign early_low = options.lvd_enable && supply_below_early;

   // -----------------------------------------------------------------
   // Reset pin catch
   // -----------------------------------------------------------------
   // Our own drive is masked so a self-driven low is not read back as
   // an external request; asserts at once, releases through two flops.
   // The mask outlives our drive by one cycle: the pin's rise back to
   // high after release must not glitch the catch into a false reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_drive_hold <= 1'b1;
      end else begin
         pin_drive_hold <= rst_pin_oe;
      end
   end

   assign pin_clr_n = rst_n &&
      (rst_pin_in || rst_pin_oe || pin_drive_hold);

   always_ff @(posedge core_clk or negedge pin_clr_n) begin
      if (!pin_clr_n) begin
         pin_meta_n <= 1'b0;
         pin_sync_n <= 1'b0;
      end else begin
         pin_meta_n <= 1'b1;
         pin_sync_n <= pin_meta_n;
      end
   end

   // Core reset needs no clock edge for a pin-caused entry
   assign core_reset_n = pin_clr_n && pin_sync_n &&
      (state == reset_seq_pkg::SEQ_RUN);

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   assign event_pulse = watchdog_underflow || illegal_opcode;
   assign active_done = cnt >= PULSE_LAST;
   assign delay_done = cnt ==
      (options.long_delay ? LONG_LAST : SHORT_LAST);
   assign fetch_done = cnt == FETCH_LAST;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= reset_seq_pkg::SEQ_ACTIVE;
         cnt <= '0;
      end else if (event_pulse || !pin_sync_n ||
                   (lvd_low && state != reset_seq_pkg::SEQ_ACTIVE)) begin
         // A watchdog or illegal-op request, or any request outside the active phase, restarts the minimum pulse
         state <= reset_seq_pkg::SEQ_ACTIVE;
         if (state != reset_seq_pkg::SEQ_ACTIVE || event_pulse) begin
            cnt <= '0;
         end else if (!active_done) begin
            cnt <= cnt + 1'b1;
         end
      end else begin
         unique case (state)
            reset_seq_pkg::SEQ_ACTIVE: begin
               if (active_done && !lvd_low) begin
                  state <= reset_seq_pkg::SEQ_DELAY;
                  cnt <= '0;
               end else if (!active_done) begin
                  cnt <= cnt + 1'b1;
               end
            end
            reset_seq_pkg::SEQ_DELAY: begin
               if (delay_done) begin
                  state <= reset_seq_pkg::SEQ_FETCH;
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            reset_seq_pkg::SEQ_FETCH: begin
               if (fetch_done) begin
                  state <= reset_seq_pkg::SEQ_RUN;
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            reset_seq_pkg::SEQ_RUN: begin
               cnt <= '0;
            end
         endcase
      end
   end

   // Cause of the sequence now running
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         source <= reset_seq_pkg::SRC_POWER;
      end else if (lvd_low) begin
         source <= reset_seq_pkg::SRC_UNDERVOLT;
      end else if (watchdog_underflow) begin
         source <= reset_seq_pkg::SRC_WATCHDOG;
      end else if (!pin_sync_n) begin
         source <= reset_seq_pkg::SRC_PIN;
      end else if (illegal_opcode) begin
         source <= reset_seq_pkg::SRC_ILLEGAL;
      end
   end

   // -----------------------------------------------------------------
   // Pin drive and vector fetch
   // -----------------------------------------------------------------
   assign rst_pin_out = 1'b0;
   // Open drain: low through active and delay phases
   assign rst_pin_oe = state == reset_seq_pkg::SEQ_ACTIVE ||
      state == reset_seq_pkg::SEQ_DELAY;
   assign vector_fetch = state == reset_seq_pkg::SEQ_FETCH;
   assign vector_addr = reset_seq_pkg::RESET_VECTOR_ADDR |
      {15'h0000, cnt[0]};

   // -----------------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------------
   // No wait state: read data is captured in setup so it leaves a flop
   assign rd_setup = apb_req.psel && !apb_req.penable;
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite &&
      reg_hit(apb_req) && !halt_mode;
   // One driver for the whole response word
   assign apb_rsp = '{prdata: rd_data,
      pready: apb_req.psel && apb_req.penable,
      pslverr: apb_req.psel && apb_req.penable && !reg_hit(apb_req)};

   always_comb begin
      status = reset_seq_pkg::SUPPLY_CTRL_STATUS_RESET;
      status[reset_seq_pkg::IRQ_ENABLE_BIT] = irq_enable;
      status[reset_seq_pkg::EARLY_FLAG_BIT] = early_flag;
      status[reset_seq_pkg::UNDERVOLT_BIT] = undervolt_flag;
      status[reset_seq_pkg::PLL_LOCK_BIT] = pll_lock_flag;
      status[reset_seq_pkg::WDG_CAUSE_BIT] = wdg_flag;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_setup) begin
         rd_data <= reg_hit(apb_req) ? {24'h000000, status} : '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= 1'b0;
      end else if (wr_en) begin
         irq_enable <= apb_req.pwdata[reset_seq_pkg::IRQ_ENABLE_BIT];
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   // Halt freezes the live flags; the undervoltage and watchdog cause flags can still be set
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         early_flag <= 1'b0;
         pll_lock_flag <= 1'b0;
      end else if (!halt_mode) begin
         early_flag <= early_low;
         pll_lock_flag <= pll_locked;
      end
   end

   // Hardware set beats a software clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         undervolt_flag <= 1'b0;
      end else if (lvd_low) begin
         undervolt_flag <= 1'b1;
      end else if (wr_en &&
                   !apb_req.pwdata[reset_seq_pkg::UNDERVOLT_BIT]) begin
         undervolt_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdg_flag <= 1'b0;
      end else if (watchdog_underflow && !lvd_low) begin
         wdg_flag <= 1'b1;
      end else if (lvd_low || !pin_sync_n) begin
         wdg_flag <= 1'b0;
      end else if (wr_en &&
                   !apb_req.pwdata[reset_seq_pkg::WDG_CAUSE_BIT]) begin
         wdg_flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Early-warning request
   // -----------------------------------------------------------------
   // Only a rise makes a request; recovery is left for software to poll
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending <= 1'b0;
      end else if (!halt_mode && irq_enable && early_low &&
                   !early_flag) begin
         irq_pending <= 1'b1;
      end else if (irq_entered) begin
         irq_pending <= 1'b0;
      end
   end

   assign early_warning_irq = irq_pending && !halt_mode;
   assign wait_wakeup = irq_pending && wait_mode;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   chk_delay_pin_low: assert property (
      state == reset_seq_pkg::SEQ_DELAY |-> rst_pin_oe && !core_reset_n)
      else $error("pin released during delay");

   chk_fetch_two_cycles: assert property (
      $rose(vector_fetch) |-> ##1 vector_fetch ##1 !vector_fetch)
      else $error("vector fetch not two cycles");

   chk_fetch_address: assert property (
      $rose(vector_fetch) |->
         vector_addr == 16'hFFFE ##1 vector_addr == 16'hFFFF)
      else $error("wrong vector address");

   chk_delay_length: assert property (
      $rose(vector_fetch) |-> $past(cnt) ==
         (options.long_delay ? LONG_LAST : SHORT_LAST))
      else $error("delay length wrong");

   chk_min_pulse: assert property (
      $past(state) == reset_seq_pkg::SEQ_ACTIVE &&
      state == reset_seq_pkg::SEQ_DELAY |-> $past(cnt) >= PULSE_LAST)
      else $error("reset pulse too short");

   chk_watchdog_seq: assert property (
      watchdog_underflow |=> state == reset_seq_pkg::SEQ_ACTIVE &&
         cnt == '0 && rst_pin_oe)
      else $error("watchdog did not restart reset");

   chk_lvd_hold: assert property (
      lvd_low |=> rst_pin_oe)
      else $error("pin free while supply low");

   chk_pin_async: assert property (
      !rst_pin_in |-> !core_reset_n)
      else $error("core left running with pin low");

   chk_early_raise: assert property (
      irq_enable && early_low && !early_flag && !halt_mode && !irq_entered
      |=> early_warning_irq && early_flag)
      else $error("early warning not raised");

   chk_no_recover_irq: assert property (
      $fell(early_flag) |-> !$rose(irq_pending))
      else $error("recovery raised a request");

   chk_halt_freeze: assert property (
      halt_mode && $past(halt_mode) |-> $stable(status))
      else $error("register moved in halt");

   chk_uv_sticky: assert property (
      undervolt_flag && !wr_en |=> undervolt_flag)
      else $error("undervoltage flag lost");

   chk_wdg_cause: assert property (
      watchdog_underflow && !lvd_low |=> wdg_flag ##1 (wdg_flag ||
         $past(wr_en) || $past(!pin_sync_n) || $past(lvd_low)))
      else $error("watchdog flag not kept");

   chk_reserved_zero: assert property (
      apb_rsp.prdata[31:7] == '0 && apb_rsp.prdata[2:1] == 2'b00)
      else $error("reserved bits read nonzero");

   cov_long_delay: cover property (
      options.long_delay && $rose(vector_fetch));
   cov_uv_reset: cover property (lvd_low ##1 rst_pin_oe [*3]);
   cov_early_irq: cover property ($rose(early_warning_irq));
   cov_pin_reset: cover property ($fell(rst_pin_in) ##[1:20] rst_pin_oe);

endmodule

/* File: sim/reset_pin_partner.sv */
// -----------------------------------------------------------------
// Board side of the shared reset pin
// -----------------------------------------------------------------
// Models the external reset circuit and the other devices on the pin.
// Assumes the device drives only low (open drain) when its enable is up.
`timescale 1ns/1ps

module reset_pin_partner (
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic ext_pull,
   output logic pin_level
);
   // Weak pull-up: a released pin returns high at once, never holds low
   assign pin_level = !(dev_oe && !dev_out) && !ext_pull;
endmodule

/* File: sim/tb_top.sv */
// -----------------------------------------------------------------
// Self-checking bench of the reset sequencer
// -----------------------------------------------------------------
// Drives APB, options, comparators and the shared pin through the partner.
// Assumes shortened counts: 100 ns pulse, delays of 8 and 16 cycles.
`timescale 1ns/1ps

module tb_top;
   localparam int PULSE = 100 / 20;
   localparam int DS = 8;
   localparam int DL = 16;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   reset_seq_pkg::apb_req_t apb_req = '0;
   reset_seq_pkg::apb_rsp_t apb_rsp;
   reset_seq_pkg::option_t options = '0;
   logic rst_pin_in, rst_pin_out, rst_pin_oe, ext_pull = 1'b0;
   logic supply_below_lvd = 1'b0, supply_below_early = 1'b0;
   logic watchdog_underflow = 1'b0, illegal_opcode = 1'b0;
   logic pll_locked = 1'b0, halt_mode = 1'b0, wait_mode = 1'b0;
   logic irq_entered = 1'b0;
   logic lvd_enable, early_warning_enable, core_reset_n, vector_fetch;
   logic early_warning_irq, wait_wakeup;
   logic [1:0] lvd_threshold_sel;
   logic [15:0] vector_addr;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int checks_done = 0;

   reset_sequencer #(.MIN_PULSE_NS(100), .DELAY_SHORT_CYC(DS),
      .DELAY_LONG_CYC(DL)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .options(options), .supply_below_lvd(supply_below_lvd),
      .supply_below_early(supply_below_early),
      .watchdog_underflow(watchdog_underflow),
      .illegal_opcode(illegal_opcode), .pll_locked(pll_locked),
      .halt_mode(halt_mode), .wait_mode(wait_mode),
      .irq_entered(irq_entered), .lvd_enable(lvd_enable),
      .lvd_threshold_sel(lvd_threshold_sel),
      .early_warning_enable(early_warning_enable),
      .core_reset_n(core_reset_n), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .early_warning_irq(early_warning_irq),
      .wait_wakeup(wait_wakeup));

   reset_pin_partner board (.dev_out(rst_pin_out), .dev_oe(rst_pin_oe),
      .ext_pull(ext_pull), .pin_level(rst_pin_in));

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [7:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
         pwdata: {24'h000000, d}};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      @(posedge core_clk);
      while (apb_rsp.pready !== 1'b1 && k < 20) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 20) begin
         n_errors++;
         complete_run();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Counts cycles with the pin driven, then checks the vector fetch
   task automatic watch_seq(input int lo, input int hi);
      int n;
      int k;
      n = 0;
      k = 0;
      while (vector_fetch !== 1'b1 && k < 300) begin
         @(posedge core_clk);
         #1;
         if (rst_pin_oe === 1'b1) n++;
         k++;
      end
      if (k >= 300) begin
         n_errors++;
         complete_run();
      end
      check(n >= lo && n <= hi, 1'b1);
      check(vector_addr, 16'hFFFE);
      check(core_reset_n, 1'b0);
      @(posedge core_clk);
      #1;
      check({vector_fetch, vector_addr}, 17'h1FFFF);
      @(posedge core_clk);
      #1;
      check({vector_fetch, core_reset_n}, 2'b01);
   endtask

   // One-cycle pulse: 0 watchdog, 1 illegal opcode, else service entry
   task automatic pulse(input int which);
      @(posedge core_clk);
      if (which == 0) begin
         watchdog_underflow <= 1'b1;
      end else if (which == 1) begin
         illegal_opcode <= 1'b1;
      end else begin
         irq_entered <= 1'b1;
      end
      @(posedge core_clk);
      watchdog_underflow <= 1'b0;
      illegal_opcode <= 1'b0;
      irq_entered <= 1'b0;
   endtask

   task automatic flags(input logic [7:0] exp);
      apb(1'b0, 12'h000, 8'h00);
      check(rd[7:0] & 8'h11, exp);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, 12'h000, 8'h00);
      check({err, rd}, 33'h0);
      apb(1'b1, 12'h004, 8'h40);
      check(err, 1'b1);
      apb(1'b0, 12'h004, 8'h00);
      check({err, rd}, 33'h100000000);
      pll_locked <= 1'b1;
      apb(1'b0, 12'h000, 8'h00);
      check(rd, 32'h08);
      pll_locked <= 1'b0;
      apb(1'b0, 12'h000, 8'h00);
      check(rd, 32'h00);
   endtask

   task automatic t_options();
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         options <= '{lvd_enable: 1'b1, lvd_level: 2'(i), long_delay: 1'b0};
         @(posedge core_clk);
         #1;
         check({lvd_enable, early_warning_enable, lvd_threshold_sel},
            {2'b11, 2'(i)});
      end
      options.lvd_enable <= 1'b0;
      @(posedge core_clk);
      #1;
      check({lvd_enable, early_warning_enable}, 2'b00);
   endtask

   task automatic t_resets();
      pulse(0);
      watch_seq(PULSE + DS - 1, PULSE + DS - 1);
      flags(8'h01);
      options.long_delay <= 1'b1;
      pulse(1);
      watch_seq(PULSE + DL - 1, PULSE + DL - 1);
      flags(8'h01);
      options <= '{lvd_enable: 1'b1, lvd_level: 2'd1, long_delay: 1'b0};
      @(posedge core_clk);
      supply_below_lvd <= 1'b1;
      repeat (19) @(posedge core_clk);
      #1;
      check({rst_pin_oe, core_reset_n}, 2'b10);
      @(posedge core_clk);
      supply_below_lvd <= 1'b0;
      // Active phase already spent while the supply was low
      watch_seq(DS, DS);
      flags(8'h10);
      pulse(0);
      watch_seq(PULSE + DS - 1, PULSE + DS - 1);
      flags(8'h11);
      @(posedge core_clk);
      #5;
      ext_pull = 1'b1;
      #2;
      check(core_reset_n, 1'b0);
      @(posedge core_clk);
      ext_pull <= 1'b0;
      watch_seq(PULSE + DS - 2, PULSE + DS + 4);
      flags(8'h10);
   endtask

   task automatic t_write();
      apb(1'b1, 12'h000, 8'h00);
      flags(8'h00);
      apb(1'b1, 12'h000, 8'h79);
      apb(1'b0, 12'h000, 8'h00);
      check(rd, 32'h40);
      halt_mode <= 1'b1;
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b0, 12'h000, 8'h00);
      check(rd, 32'h40);
      halt_mode <= 1'b0;
   endtask

   task automatic t_early();
      @(posedge core_clk);
      supply_below_early <= 1'b1;
      wait_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check({early_warning_irq, wait_wakeup}, 2'b11);
      pulse(2);
      #1;
      check({early_warning_irq, wait_wakeup}, 2'b00);
      apb(1'b0, 12'h000, 8'h00);
      check(rd, 32'h60);
      supply_below_early <= 1'b0;
      apb(1'b0, 12'h000, 8'h00);
      check({early_warning_irq, rd}, 33'h40);
      halt_mode <= 1'b1;
      supply_below_early <= 1'b1;
      apb(1'b0, 12'h000, 8'h00);
      check({early_warning_irq, rd}, 33'h40);
      supply_below_early <= 1'b0;
      halt_mode <= 1'b0;
      options.lvd_enable <= 1'b0;
      @(posedge core_clk);
      supply_below_early <= 1'b1;
      apb(1'b0, 12'h000, 8'h00);
      check({early_warning_irq, rd}, 33'h40);
   endtask

   // Whole run is a few hundred cycles; this only cuts a hang short
   initial begin
      #1000000;
      n_errors++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      watch_seq(PULSE + DS - 1, PULSE + DS + 3);
      t_regs();
      t_options();
      t_resets();
      t_write();
      t_early();
      complete_run();
   end
endmodule
